// [inc/sdram_cfg.svh]
/*
 Constants for the SDRAM control-pin block: geometry, command codes,
 mask latency and buffer depth. Included by the package and the design.
*/
`ifndef SDRAM_CFG_SVH
`define SDRAM_CFG_SVH
`define BANK_W     2
`define ROW_W      12
`define COL_W      9
`define DATA_W     16
`define LANE_W     8
`define LEFT_W     10
`define ROWS       4096
`define COLS       512
`define CL_DEFAULT 2
`define DQM_RD_LAT 2
`define FIFO_DEPTH 16
`define AP_BIT     10
`define BL_FIELD   2:0
`define BL_FULL    3'h7
`define BL_MAXCODE 3'h3
`define MRS_BASE   2'h0
// {selectN, rowStrobeN, colStrobeN, writeStrobeN}
`define CMD_NOP    4'h7
`define CMD_ACT    4'h3
`define CMD_RD     4'h5
`define CMD_WR     4'h4
`define CMD_BST    4'h6
`define CMD_PRE    4'h2
`define CMD_REF    4'h1
`define CMD_MRS    4'h0
`endif

// [inc/sdram_pkg.sv]
/*
 Types shared by the SDRAM control-pin block: pin bundle, decoded
 commands, power states, control state and buffered write words.
*/
`include "sdram_cfg.svh"
package sdram_pkg;
	typedef struct packed {
		logic selectN;
		logic rowStrobeN;
		logic colStrobeN;
		logic writeStrobeN;
	} cmdPins_t;
	typedef enum logic [3:0] {
		CMD_INHIBIT, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR,
		CMD_BST, CMD_PRE, CMD_REF, CMD_MRS
	} cmd_t;
	typedef enum logic [2:0] {
		PWR_RUN, PWR_SUSPEND, PWR_DOWN_PRE, PWR_DOWN_ACT, PWR_SELF_REF
	} pwr_t;
	typedef enum logic [1:0] {B_NONE, B_RD, B_WR} burst_t;
	typedef struct packed {
		pwr_t                           pwr;
		burst_t                         burst;
		logic [`BANK_W-1:0]             bank;
		logic [`COL_W-1:0]              col;
		logic [`LEFT_W-1:0]             left;
		logic                           autoPre;
		logic [2:0]                     blCode;
		logic [3:0]                     rowOpen;
		logic [3:0][`ROW_W-1:0]         openRow;
	} ctrl_t;
	typedef struct packed {
		logic [`BANK_W-1:0]             bank;
		logic [`ROW_W-1:0]              row;
		logic [`COL_W-1:0]              col;
		logic [1:0]                     mask;
		logic [`DATA_W-1:0]             data;
	} wrWord_t;
endpackage : sdram_pkg

// [logic/sdram_control_pin_interface.sv]
/*
 SDRAM device side of the control pins: command decode, clock-enable
 power states, burst engine, byte masks, storage array and write FIFO.
 Assumes a controller driving all inputs synchronous to core_clk and
 resolving the data wire from dqOut/dqOeN outside this file.
*/
`timescale 1ns/1ps
`include "sdram_cfg.svh"

module sdram_wr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input  wire logic             core_clk,
	input  wire logic             rstn,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [AW:0]      cnt_q, cnt_d;
	logic             push, pop;

	assign inReady  = cnt_q != (AW+1)'(DEPTH);
	assign outValid = cnt_q != '0;
	assign outData  = store[rdPtr_q];

	always_comb begin
		push = inValid && inReady;
		pop = outValid && outReady;
		wrPtr_d = wrPtr_q;
		rdPtr_d = rdPtr_q;
		if (push) begin
			wrPtr_d = (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
		end
		if (pop) begin
			rdPtr_d = (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
		end
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			cnt_q <= '0;
		end else begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (push) begin
			store[wrPtr_q] <= inData;
		end
	end
endmodule : sdram_wr_fifo

module sdram_control_pin_interface #(
	parameter int CAS_LAT = `CL_DEFAULT,
	parameter int ROWS    = `ROWS,
	parameter int COLS    = `COLS
) (
	input  wire sdram_pkg::cmdPins_t cmdPins,
	input  wire logic                core_clk,
	input  wire logic                rstn,
	input  wire logic                clkEnable,
	input  wire logic                bank_select_lsb,
	input  wire logic                bank_select_msb,
	input  wire logic [`ROW_W-1:0]   addr,
	input  wire logic                lower_byte_mask,
	input  wire logic                upper_byte_mask,
	input  wire logic [`DATA_W-1:0]  dqIn,
	output logic      [`DATA_W-1:0]  dqOut,
	output logic      [1:0]          dqOeN,
	output logic                     writeReady,
	output sdram_pkg::pwr_t          powerState
);
	import sdram_pkg::*;

	typedef struct packed {
		logic               valid;
		logic [`DATA_W-1:0] data;
	} rdStage_t;

	logic [`DATA_W-1:0] mem [4*ROWS*COLS];
	ctrl_t              st_q, st_d;
	rdStage_t           rdPipe_q [CAS_LAT];
	rdStage_t           rdPipe_d [CAS_LAT];
	logic [1:0]         mskPipe_q [`DQM_RD_LAT-1];
	logic [1:0]         mskPipe_d [`DQM_RD_LAT-1];
	logic [1:0]         dqOeN_d;
	logic               writeReady_q;
	cmd_t               cmd;
	logic [`BANK_W-1:0] bank, accBank;
	burst_t             accMode;
	logic [`COL_W-1:0]  accCol;
	logic [`LEFT_W-1:0] accLeft;
	logic               accAp, rdStep, wrStep, pushValid, fifoReady;
	wrWord_t            pushWord, drainWord;
	logic               drainValid;

	function automatic cmd_t decodeCmd(input cmdPins_t p);
		if (p.selectN) begin
			return CMD_INHIBIT;
		end
		case (p)
			`CMD_NOP: return CMD_NOP;
			`CMD_ACT: return CMD_ACT;
			`CMD_RD:  return CMD_RD;
			`CMD_WR:  return CMD_WR;
			`CMD_BST: return CMD_BST;
			`CMD_PRE: return CMD_PRE;
			`CMD_REF: return CMD_REF;
			`CMD_MRS: return CMD_MRS;
			default:  return CMD_NOP;
		endcase
	endfunction : decodeCmd

	function automatic logic [`LEFT_W-1:0] burstLen(input logic [2:0] code);
		if (code == `BL_FULL) begin
			return `LEFT_W'(COLS);
		end
		return (code <= `BL_MAXCODE) ? `LEFT_W'(1) << code : `LEFT_W'(1);
	endfunction : burstLen

	// wraps inside the burst-aligned block, whole page for full bursts
	function automatic logic [`COL_W-1:0] nextCol(input logic [`COL_W-1:0] c,
			input logic [2:0] code);
		logic [`COL_W-1:0] m;
		m = `COL_W'(burstLen(code) - 1'b1);
		return (c & ~m) | ((c + 1'b1) & m);
	endfunction : nextCol

	function automatic int memIdx(input logic [`BANK_W-1:0] b,
			input logic [`ROW_W-1:0] r, input logic [`COL_W-1:0] c);
		return (int'(b) * ROWS + int'(r)) * COLS + int'(c);
	endfunction : memIdx

	always_comb begin
		st_d = st_q;
		cmd = decodeCmd(cmdPins);
		bank = {bank_select_msb, bank_select_lsb};
		accMode = st_q.burst;
		accBank = st_q.bank;
		accCol = st_q.col;
		accLeft = st_q.left;
		accAp = st_q.autoPre;
		rdStep = 1'b0;
		wrStep = 1'b0;
		case (st_q.pwr)
			PWR_RUN, PWR_SUSPEND: begin
				if (!clkEnable) begin
					if (st_q.burst != B_NONE) begin
						st_d.pwr = PWR_SUSPEND;
					end else if (st_q.rowOpen != '0) begin
						st_d.pwr = PWR_DOWN_ACT;
					end else if (cmd == CMD_REF) begin
						st_d.pwr = PWR_SELF_REF;
					end else begin
						st_d.pwr = PWR_DOWN_PRE;
					end
				end else begin
					st_d.pwr = PWR_RUN;
					case (cmd)
						CMD_ACT: begin
							st_d.rowOpen[bank] = 1'b1;
							st_d.openRow[bank] = addr;
						end
						CMD_RD, CMD_WR: begin
							accMode = (cmd == CMD_RD) ? B_RD : B_WR;
							accBank = bank;
							accCol = addr[`COL_W-1:0];
							accLeft = burstLen(st_q.blCode);
							accAp = addr[`AP_BIT];
						end
						CMD_BST: accMode = B_NONE;
						CMD_PRE: begin
							if (addr[`AP_BIT]) begin
								st_d.rowOpen = '0;
							end else begin
								st_d.rowOpen[bank] = 1'b0;
							end
						end
						CMD_MRS: begin
							if (bank == `MRS_BASE) begin
								st_d.blCode = addr[`BL_FIELD];
							end
						end
						default: ;
					endcase
					// deselected cycles fall through here untouched
					rdStep = accMode == B_RD;
					wrStep = accMode == B_WR;
					st_d.bank = accBank;
					st_d.autoPre = accAp;
					if (accMode == B_NONE || accLeft <= `LEFT_W'(1)) begin
						st_d.burst = B_NONE;
						if (accMode != B_NONE && accAp) begin
							st_d.rowOpen[accBank] = 1'b0;
						end
					end else begin
						st_d.burst = accMode;
						st_d.left = accLeft - 1'b1;
						st_d.col = nextCol(accCol, st_q.blCode);
					end
				end
			end
			// input buffers dead: only clock enable is looked at
			PWR_DOWN_PRE, PWR_DOWN_ACT, PWR_SELF_REF: begin
				if (clkEnable) begin
					st_d.pwr = PWR_RUN;
				end
			end
			default: st_d.pwr = PWR_RUN;
		endcase
	end

	always_comb begin
		pushWord.bank = accBank;
		pushWord.row = st_q.openRow[accBank];
		pushWord.col = accCol;
		pushWord.mask = {upper_byte_mask, lower_byte_mask};
		pushWord.data = dqIn;
		pushValid = wrStep && !(lower_byte_mask && upper_byte_mask);
		rdPipe_d[0].valid = rdStep;
		rdPipe_d[0].data = mem[memIdx(accBank, st_q.openRow[accBank], accCol)];
		for (int i = 1; i < CAS_LAT; i++) begin
			rdPipe_d[i] = rdPipe_q[i-1];
		end
		mskPipe_d[0] = {upper_byte_mask, lower_byte_mask};
		for (int i = 1; i < `DQM_RD_LAT - 1; i++) begin
			mskPipe_d[i] = mskPipe_q[i-1];
		end
		dqOeN_d = {2{!rdPipe_d[CAS_LAT-1].valid}}
			| mskPipe_q[`DQM_RD_LAT-2];
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
			dqOeN <= 2'h3;
			writeReady_q <= 1'b0;
			for (int i = 0; i < CAS_LAT; i++) begin
				rdPipe_q[i] <= '0;
			end
			for (int i = 0; i < `DQM_RD_LAT - 1; i++) begin
				mskPipe_q[i] <= 2'h0;
			end
		end else begin
			st_q <= st_d;
			dqOeN <= dqOeN_d;
			writeReady_q <= fifoReady;
			rdPipe_q <= rdPipe_d;
			mskPipe_q <= mskPipe_d;
		end
	end

	assign dqOut = rdPipe_q[CAS_LAT-1].data;
	assign powerState = st_q.pwr;
	assign writeReady = writeReady_q;

	// a full buffer drops the word; reads see only drained data
	sdram_wr_fifo #(.WIDTH($bits(wrWord_t)), .DEPTH(`FIFO_DEPTH)) wrBuf (
		.core_clk (core_clk),
		.rstn     (rstn),
		.inValid  (pushValid),
		.inReady  (fifoReady),
		.inData   (pushWord),
		.outValid (drainValid),
		.outReady (!rdStep),
		.outData  (drainWord)
	);

	// single array port: reads win, draining stalls
	always_ff @(posedge core_clk) begin
		if (drainValid && !rdStep) begin
			for (int l = 0; l < 2; l++) begin
				if (!drainWord.mask[l]) begin
					mem[memIdx(drainWord.bank, drainWord.row, drainWord.col)]
						[l*`LANE_W +: `LANE_W] <= drainWord.data[l*`LANE_W +: `LANE_W];
				end
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence burstStep;
		st_q.burst != B_NONE && clkEnable && cmdPins.selectN && st_q.left > 1;
	endsequence

	chk_dqm_read_float: assert property (
		$past(lower_byte_mask, 2) |-> dqOeN[0]) else $error("low lane not floated");
	chk_deselect_ignored: assert property (
		st_q.pwr == PWR_RUN && clkEnable && cmdPins.selectN && st_q.burst == B_NONE
		|=> st_q.burst == B_NONE) else $error("command taken while deselected");
	chk_burst_continues: assert property (
		burstStep |=> st_q.burst == $past(st_q.burst)) else $error("burst dropped");
	chk_column_advance: assert property (
		burstStep |=> st_q.col == nextCol($past(st_q.col), st_q.blCode))
		else $error("column not advanced");
	chk_write_mask: assert property (
		wrStep && lower_byte_mask && upper_byte_mask |-> !pushValid)
		else $error("masked write buffered");
	chk_clock_suspend: assert property (
		st_q.burst != B_NONE && !clkEnable
		|=> st_q.pwr == PWR_SUSPEND && $stable(st_q.col)) else $error("no suspend");
	chk_power_down_hold: assert property (
		(st_q.pwr == PWR_DOWN_PRE || st_q.pwr == PWR_SELF_REF) && !clkEnable
		|=> $stable(st_q)) else $error("state moved in power-down");
	chk_precharge_all: assert property (
		st_q.pwr == PWR_RUN && clkEnable && cmd == CMD_PRE && addr[`AP_BIT]
		|=> st_q.rowOpen == '0) else $error("precharge all missed a bank");
	chk_activate_bank: assert property (
		st_q.pwr == PWR_RUN && clkEnable && cmd == CMD_ACT
		|=> st_q.rowOpen[$past(bank)] && st_q.openRow[$past(bank)] == $past(addr))
		else $error("activate went to wrong bank");
endmodule : sdram_control_pin_interface

// [bench/sdram_ctrl_model.sv]
/*
 Controller-side model for the SDRAM control-pin block: drives command,
 bank, address, byte-mask, clock-enable and write-data pins.
 Assumes each call to issue() starts at a falling edge of core_clk.
*/
`timescale 1ns/1ps
`include "sdram_cfg.svh"

module sdram_ctrl_model (
	input  wire logic           core_clk,
	output sdram_pkg::cmdPins_t cmdPins,
	output logic                clkEnable,
	output logic                bank_select_lsb,
	output logic                bank_select_msb,
	output logic [`ROW_W-1:0]   addr,
	output logic                lower_byte_mask,
	output logic                upper_byte_mask,
	output logic [`DATA_W-1:0]  dqIn
);
	import sdram_pkg::*;

	initial begin
		cmdPins = cmdPins_t'(`CMD_NOP);
		clkEnable = 1'b1;
		{bank_select_msb, bank_select_lsb} = 2'h0;
		addr = 12'h000;
		{upper_byte_mask, lower_byte_mask} = 2'h0;
		dqIn = 16'hA5A5;
	end

	// one command per edge; pins change only at falling edges
	task automatic issue(input logic [3:0] code, input logic [1:0] bank,
			input logic [`ROW_W-1:0] a, input logic [1:0] mask,
			input logic [`DATA_W-1:0] data, input logic drive, input logic cke);
		cmdPins = cmdPins_t'(code);
		{bank_select_msb, bank_select_lsb} = bank;
		addr = a;
		{upper_byte_mask, lower_byte_mask} = mask;
		// released bus toggles so a stale word never reads as valid
		dqIn = drive ? data : ~dqIn;
		clkEnable = cke;
		@(negedge core_clk);
	endtask : issue
endmodule : sdram_ctrl_model

// [bench/sdram_control_pin_interface_tb.sv]
/*
 Self-checking bench for the SDRAM control-pin block with a reference
 memory model. Assumes CAS latency 2 and a write buffer that drains
 within 20 idle cycles.
*/
`timescale 1ns/1ps
`include "sdram_cfg.svh"

module sdram_control_pin_interface_tb;
	import sdram_pkg::*;
	localparam int CL = 2;
	logic               core_clk;
	logic               rstn;
	cmdPins_t           cmdPins;
	logic               clkEnable, bank_select_lsb, bank_select_msb;
	logic               lower_byte_mask, upper_byte_mask, writeReady;
	logic [`ROW_W-1:0]  addr, row;
	logic [`DATA_W-1:0] dqIn, dqOut;
	logic [1:0]         dqOeN, bank, mask;
	pwr_t               powerState, expPwr;
	logic [15:0]        mem [int];
	logic [8:0]         col;
	logic [8:0]         cols [$];
	int                 failures, check_count, cycles;

	sdram_ctrl_model ctl (.core_clk(core_clk), .cmdPins(cmdPins), .clkEnable(clkEnable),
		.bank_select_lsb(bank_select_lsb), .bank_select_msb(bank_select_msb), .addr(addr),
		.lower_byte_mask(lower_byte_mask), .upper_byte_mask(upper_byte_mask), .dqIn(dqIn));

	sdram_control_pin_interface #(.CAS_LAT(CL), .ROWS(`ROWS), .COLS(`COLS)) dut (
		.cmdPins(cmdPins), .core_clk(core_clk), .rstn(rstn), .clkEnable(clkEnable),
		.bank_select_lsb(bank_select_lsb), .bank_select_msb(bank_select_msb), .addr(addr),
		.lower_byte_mask(lower_byte_mask), .upper_byte_mask(upper_byte_mask), .dqIn(dqIn),
		.dqOut(dqOut), .dqOeN(dqOeN), .writeReady(writeReady), .powerState(powerState));

	initial core_clk = 1'b0;
	always #10 core_clk = ~core_clk;

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic close_out();
		$display("checks %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out

	task automatic cmd(input logic [3:0] code, input logic [`ROW_W-1:0] a,
			input logic [1:0] m = 2'h0, input logic cke = 1'b1);
		ctl.issue(code, bank, a, m, dqIn, 1'b0, cke);
	endtask : cmd

	task automatic mrs(input logic [3:0] code, input logic [2:0] bl);
		ctl.issue(code, 2'h0, {9'h000, bl}, 2'h0, dqIn, 1'b0, 1'b1);
	endtask : mrs

	// reference store keeps unmasked lanes only
	task automatic wr(input logic [3:0] code, input logic [8:0] c, input logic [1:0] m,
			input logic [15:0] d);
		int k;
		k = int'({bank, row, c});
		if (!m[0]) mem[k][7:0] = d[7:0];
		if (!m[1]) mem[k][15:8] = d[15:8];
		ctl.issue(code, bank, {3'h0, c}, m, d, 1'b1, 1'b1);
	endtask : wr

	task automatic chkWord(input logic [8:0] c, input logic [1:0] m);
		logic [15:0] e;
		e = mem[int'({bank, row, c})];
		if (m[0]) e[7:0] = dqOut[7:0];
		if (m[1]) e[15:8] = dqOut[15:8];
		check({14'h0, dqOeN}, {14'h0, m});
		check(dqOut, e);
	endtask : chkWord

	task automatic chkPwr(input pwr_t p);
		check({13'h0, powerState}, {13'h0, p});
	endtask : chkPwr

	always @(posedge core_clk) begin
		cycles++;
		if (cycles >= 3000) begin
			failures++;
			close_out();
		end
	end

	initial begin
		void'($urandom(58));
		rstn = 1'b0;
		bank = 2'($urandom);
		row = 12'($urandom);
		repeat (5) @(negedge core_clk);
		chkPwr(PWR_RUN);
		check({14'h0, dqOeN}, 16'h0003);
		rstn = 1'b1;
		@(negedge core_clk);
		check({15'h0, writeReady}, 16'h0001);
		mrs(`CMD_MRS, 3'h0);
		cmd(`CMD_ACT, row);
		for (int i = 0; i < 6; i++) begin
			col = 9'($urandom);
			cols.push_back(col);
			wr(`CMD_WR, col, 2'h0, 16'($urandom));
			wr(`CMD_WR, col, 2'($urandom), 16'($urandom));
		end
		repeat (20) cmd(`CMD_NOP, 12'h000);
		foreach (cols[i]) begin
			mask = 2'($urandom);
			cmd(`CMD_RD, {3'h0, cols[i]}, mask);
			cmd(`CMD_NOP, 12'h000);
			chkWord(cols[i], mask);
		end
		cmd(4'hD, {3'h0, cols[0]});
		cmd(`CMD_NOP, 12'h000);
		check({14'h0, dqOeN}, 16'h0003);
		// two-word burst, second word wraps inside its aligned pair
		mrs(`CMD_MRS, 3'h1);
		wr(`CMD_WR, 9'h004, 2'h0, 16'($urandom));
		wr(`CMD_NOP, 9'h005, 2'h0, 16'($urandom));
		repeat (20) cmd(`CMD_NOP, 12'h000);
		cmd(`CMD_RD, 12'h005);
		mrs(4'h8, 3'h0);
		chkWord(9'h005, 2'h0);
		cmd(`CMD_NOP, 12'h000);
		chkWord(9'h004, 2'h0);
		cmd(`CMD_NOP, 12'h000);
		check({14'h0, dqOeN}, 16'h0003);
		// four-word burst: masked, deselected, suspended and stopped steps
		mrs(`CMD_MRS, 3'h2);
		wr(`CMD_WR, 9'h004, 2'h3, 16'($urandom));
		wr(`CMD_NOP, 9'h005, 2'h1, 16'($urandom));
		wr(4'hF, 9'h006, 2'h0, 16'($urandom));
		wr(`CMD_NOP, 9'h007, 2'h0, 16'($urandom));
		repeat (20) cmd(`CMD_NOP, 12'h000);
		cmd(`CMD_RD, 12'h005);
		cmd(4'hF, 12'h000);
		chkWord(9'h005, 2'h0);
		cmd(`CMD_NOP, 12'h000, 2'h0, 1'b0);
		chkWord(9'h006, 2'h0);
		chkPwr(PWR_SUSPEND);
		cmd(`CMD_NOP, 12'h000);
		check({14'h0, dqOeN}, 16'h0003);
		chkPwr(PWR_RUN);
		cmd(`CMD_BST, 12'h000);
		chkWord(9'h007, 2'h0);
		cmd(`CMD_NOP, 12'h000);
		check({14'h0, dqOeN}, 16'h0003);
		// single read with auto precharge closes the only open bank
		mrs(`CMD_MRS, 3'h0);
		cmd(`CMD_RD, 12'h404);
		cmd(`CMD_NOP, 12'h000, 2'h0, 1'b0);
		chkWord(9'h004, 2'h0);
		chkPwr(PWR_DOWN_PRE);
		cmd(`CMD_NOP, 12'h000);
		for (int i = 0; i < 3; i++) begin
			cmd(i == 1 ? `CMD_ACT : `CMD_PRE, 12'h400);
			cmd(i == 2 ? `CMD_REF : `CMD_NOP, 12'h000, 2'h0, 1'b0);
			expPwr = i == 0 ? PWR_DOWN_PRE : (i == 1 ? PWR_DOWN_ACT : PWR_SELF_REF);
			chkPwr(expPwr);
			cmd(`CMD_PRE, 12'h400, 2'h0, 1'b0);
			chkPwr(expPwr);
			cmd(`CMD_NOP, 12'h000);
			chkPwr(PWR_RUN);
			cmd(`CMD_NOP, 12'h000, 2'h0, 1'b0);
			chkPwr(i == 1 ? PWR_DOWN_ACT : PWR_DOWN_PRE);
			cmd(`CMD_NOP, 12'h000);
		end
		close_out();
	end
endmodule : sdram_control_pin_interface_tb
